// File: design/bbs_pkg.sv
// Constants, types and register map of the buck-boost sequencer
// ************************************************************
// Summary of operation
// - Enable with input good: bias, settle 100us
// - Sample config resistor 200us, decode address/limit/feedback
// - IO supply valid before serial port, soft-start
// - Enable during discharge waits for discharge end
// - Soft-start ramps reference over 2ms
// - Soft-start clamps current limit to 3.8A code
// - One variant latches off without power-good
// - Enable low: stop, clear registers, discharge
// - Discharge ends at 2.5V or 600ms timer
// - Input or IO undervoltage: full shutdown, clear
// - Thermal, overcurrent 427us, startup failure latch off
// - Discharge on every disable except thermal
// - Enable pin ignored while discharging
// - Discharge switch open while regulating
// - Two-bit frequency field, default 1.8MHz
// - Three switch phases drive fixed switch pairs
// - Light load skips between upper/lower thresholds
// - Forced-PWM bit forces fixed-frequency PWM
// - Target change forces PWM, step-down thresholds
// - Bus limit setting overrides config resistor limit; address and feedback stay
// - Eight limits, four slews, four addresses
// - IO supply invalid holds registers cleared
// - Enable active high, floating reads disabled
// ************************************************************
package bbs_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CNT_W         = 24;
  localparam int CLK_PERIOD_NS = 50;
  localparam int BIAS_TIME_US  = 100;
  localparam int CFG_TIME_US   = 200;
  localparam int SS_TIME_MS    = 2;
  localparam int DIS_TIME_MS   = 600;
  localparam int OCP_TIME_US   = 427;
  localparam logic [CNT_W-1:0] BIAS_CYC =
    CNT_W'((BIAS_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CFG_CYC =
    CNT_W'((CFG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int SS_CYC_DEF  = SS_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DIS_CYC_DEF = DIS_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int OCP_CYC_DEF =
    (OCP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VREF_W = 8;
  // Reference step periods in cycles for each slew code
  localparam logic [15:0] SLEW_STEP_0 = 16'h004a;
  localparam logic [15:0] SLEW_STEP_1 = 16'h0025;
  localparam logic [15:0] SLEW_STEP_2 = 16'h0093;
  localparam logic [15:0] SLEW_STEP_3 = 16'h0126;

  // ************************************************************
  // Registers
  // ************************************************************
  localparam int          ADDR_W     = 4;
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_VREF   = 4'h4;
  localparam logic [3:0]  REG_STAT   = 4'h8;
  localparam logic [3:0]  REG_CFG    = 4'hc;
  localparam int          CTRL_FORCED_PWM_BIT  = 0;
  localparam int          CTRL_SWITCHING_FREQUENCY_FIELD  = 1;
  localparam int          CTRL_SWITCH_CURRENT_LIMIT  = 4;
  localparam int          CTRL_SLEW  = 8;
  localparam int          CFG_LIMIT  = 8;
  localparam logic [2:0]  HSIZE_WORD = 3'h2;
  localparam logic [1:0]  SWITCHING_FREQUENCY_FIELD_DEF   = 2'h0;
  localparam logic [1:0]  SLEW_DEF   = 2'h0;
  localparam logic [7:0]  VREF_DEF   = 8'h07;
  localparam logic [2:0]  SWITCH_CURRENT_LIMIT_SS    = 3'h2;
  localparam logic [11:0] SWITCH_CURRENT_LIMIT_MAP   = {3'h7, 3'h5, 3'h3, 3'h1};
  localparam logic [27:0] ADDR_MAP   = {7'h6f, 7'h6e, 7'h67, 7'h66};

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_BIAS  = 3'b001,
    ST_CFG   = 3'b010,
    ST_IOCHK = 3'b011,
    ST_SOFT  = 3'b100,
    ST_RUN   = 3'b101,
    ST_LATCH = 3'b110,
    ST_DISCH = 3'b111
  } bbs_state_e;

  typedef enum logic [1:0] {
    DVS_IDLE = 2'b00,
    DVS_UP   = 2'b01,
    DVS_DNW  = 2'b10,
    DVS_DNP  = 2'b11
  } bbs_dvs_e;

  typedef enum logic [1:0] {
    PH_OFF = 2'b00,
    PH_1   = 2'b01,
    PH_2   = 2'b10,
    PH_3   = 2'b11
  } bbs_phase_e;

  typedef struct packed {
    logic       en;
    logic       vin_ok;
    logic       io_ok;
    logic       thermal;
    logic       switch_current_limit_hit;
    logic       output_power_good;
    logic       vout_low;
    logic       light_load;
    logic       below_lower;
    logic       above_upper;
    logic       mode_buck;
    logic       mode_boost;
    logic       cyc_start;
    logic       phase_end;
    logic [4:0] cfg_code;
  } bbs_ana_s;

  typedef struct packed {
    logic       bias_en;
    logic       cfg_sample_en;
    logic       serial_en;
    logic       sw_en;
    logic       dis_en;
    logic       pwm_mode;
    logic       in_hi_sw;
    logic       in_lo_sw;
    logic       out_hi_sw;
    logic       out_lo_sw;
    logic [1:0] switching_frequency_field_sel;
    logic [2:0] switch_current_limit_sel;
    logic [7:0] vref;
    logic [6:0] slave_addr;
    logic       ext_fb;
    logic       latched;
  } bbs_ctl_s;

endpackage

// File: design/bbs_sequencer.sv
// Buck-boost startup, fault, discharge and switch-phase sequencer
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
module bbs_sequencer
  import bbs_pkg::*;
#(
  parameter logic              POK_LATCH = 1'b0,
  parameter logic [CNT_W-1:0]  SS_CYC    = CNT_W'(SS_CYC_DEF),
  parameter logic [CNT_W-1:0]  DIS_CYC   = CNT_W'(DIS_CYC_DEF),
  parameter logic [CNT_W-1:0]  OCP_CYC   = CNT_W'(OCP_CYC_DEF)
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire bbs_ana_s    ana_in,
  output bbs_ctl_s         ctl_out
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    bbs_ana_s         s1;
    bbs_ana_s         s2;
    bbs_ana_s         s3;
    bbs_ana_s         filt;
    bbs_ana_s         filt_d;
    bbs_state_e       st;
    bbs_dvs_e         dynamic_target_change;
    bbs_phase_e       phase;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] ocp_cnt;
    logic [15:0]      step_cnt;
    logic [7:0]       vref_out;
    logic [7:0]       vref_goal;
    logic [7:0]       vref_reg;
    logic             forced_pwm_bit;
    logic [1:0]       switching_frequency_field;
    logic [2:0]       switch_current_limit_reg;
    logic             switch_current_limit_ovr;
    logic [1:0]       slew;
    logic [1:0]       cfg_addr;
    logic [1:0]       cfg_switch_current_limit;
    logic             cfg_ext_fb;
    logic             dis_on;
    logic             force_pwm;
    logic             burst;
    logic             ahb_wr;
    logic             ahb_rd;
    logic [3:0]       ahb_addr;
    logic             hready_q;
    logic             hresp_q;
    logic [31:0]      hrdata_q;
    bbs_ctl_s         ctl;
  } bbs_regs_s;

  localparam bbs_regs_s RST_VAL = '{
    st: ST_OFF, dynamic_target_change: DVS_IDLE, phase: PH_OFF, vref_reg: VREF_DEF,
    switching_frequency_field: SWITCHING_FREQUENCY_FIELD_DEF, slew: SLEW_DEF, hready_q: 1'b1, default: '0};
  localparam logic [15:0] SS_STEP = 16'(SS_CYC >> VREF_W);

  bbs_regs_s r;
  bbs_regs_s n;

  // ************************************************************
  // Decoders
  // ************************************************************
  function automatic logic [15:0] slew_len(input logic [1:0] code);
    case (code)
      2'h0:    slew_len = SLEW_STEP_0;
      2'h1:    slew_len = SLEW_STEP_1;
      2'h2:    slew_len = SLEW_STEP_2;
      default: slew_len = SLEW_STEP_3;
    endcase
  endfunction

  // Switch pattern {in_hi, in_lo, out_hi, out_lo} per phase
  function automatic logic [3:0] sw_of(input bbs_phase_e ph);
    case (ph)
      PH_1:    sw_of = 4'b1001;
      PH_2:    sw_of = 4'b1010;
      PH_3:    sw_of = 4'b0110;
      default: sw_of = 4'b0000;
    endcase
  endfunction

  function automatic bbs_phase_e next_ph(input bbs_phase_e ph,
                                         input logic       boost);
    case (ph)
      PH_1:    next_ph = PH_2;
      PH_2:    next_ph = boost ? PH_OFF : PH_3;
      default: next_ph = PH_OFF;
    endcase
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  bbs_ana_s    f;
  logic        uv;
  logic        dis_done;
  logic        active;
  logic        regs_clear;
  logic        acc;
  logic        vref_hit;
  logic [15:0] step_len;
  logic [2:0]  lim;
  logic [3:0]  sw;

  always_comb begin
    n = r;
    f = r.filt;
    // Three-stage synchroniser, change taken when stages two/three agree
    n.s1     = ana_in;
    n.s2     = r.s1;
    n.s3     = r.s2;
    n.filt   = (~(r.s2 ^ r.s3) & r.s2) | ((r.s2 ^ r.s3) & r.filt);
    n.filt_d = r.filt;
    n.cnt    = r.cnt + CNT_W'(1);
    uv = !f.vin_ok ||
         (!f.io_ok && (r.st == ST_SOFT || r.st == ST_RUN ||
                       r.st == ST_LATCH));
    dis_done = f.vout_low || r.cnt == DIS_CYC - CNT_W'(1);
    active   = r.st == ST_BIAS || r.st == ST_CFG || r.st == ST_IOCHK ||
               r.st == ST_SOFT || r.st == ST_RUN;

    // Sequencer
    case (r.st)
      ST_OFF: begin
        n.cnt = '0;
        if (f.en && f.vin_ok) begin
          n.st = ST_BIAS;
        end
      end
      ST_BIAS: begin
        if (r.cnt == BIAS_CYC - CNT_W'(1)) begin
          n.st  = ST_CFG;
          n.cnt = '0;
        end
      end
      ST_CFG: begin
        if (r.cnt == CFG_CYC - CNT_W'(1)) begin
          n.cfg_addr   = f.cfg_code[1:0];
          n.cfg_switch_current_limit   = f.cfg_code[3:2];
          n.cfg_ext_fb = f.cfg_code[4];
          n.st         = ST_IOCHK;
        end
      end
      ST_IOCHK: begin
        n.cnt      = '0;
        n.vref_out = '0;
        if (f.io_ok) begin
          n.st = ST_SOFT;
        end
      end
      ST_SOFT: begin
        if (r.cnt == SS_CYC - CNT_W'(1)) begin
          n.cnt = '0;
          if (POK_LATCH && !f.output_power_good) begin
            n.st     = ST_LATCH;
            n.dis_on = 1'b1;
          end else begin
            n.st = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        n.cnt = '0;
      end
      ST_LATCH: begin
        if (r.dis_on && dis_done) begin
          n.dis_on = 1'b0;
        end else if (!r.dis_on && !f.en) begin
          n.st = ST_OFF;
        end
      end
      ST_DISCH: begin
        if (dis_done) begin
          n.st = ST_OFF;
        end
      end
      default: n.st = ST_OFF;
    endcase

    // Faults, lowest priority first
    if (r.st == ST_SOFT || r.st == ST_RUN) begin
      if (f.thermal) begin
        n.st     = ST_LATCH;
        n.dis_on = 1'b0;
      end else if (r.ocp_cnt == OCP_CYC - CNT_W'(1)) begin
        n.st     = ST_LATCH;
        n.dis_on = 1'b1;
        n.cnt    = '0;
      end
    end
    if (active && !f.en) begin
      n.st  = ST_DISCH;
      n.cnt = '0;
    end
    if (uv && r.st != ST_OFF && r.st != ST_DISCH) begin
      n.st  = ST_DISCH;
      n.cnt = '0;
    end
    n.ocp_cnt = ((r.st == ST_SOFT || r.st == ST_RUN) && f.switch_current_limit_hit) ?
                r.ocp_cnt + CNT_W'(1) : '0;

    // Target changes
    if (r.st == ST_RUN) begin
      case (r.dynamic_target_change)
        DVS_IDLE: begin
          if (r.vref_reg > r.vref_goal) begin
            n.vref_goal = r.vref_reg;
            n.force_pwm = 1'b1;
            n.dynamic_target_change       = DVS_UP;
          end else if (r.vref_reg < r.vref_goal) begin
            n.dynamic_target_change = DVS_DNW;
          end
        end
        DVS_UP: begin
          if (r.vref_out == r.vref_goal && f.output_power_good) begin
            n.force_pwm = 1'b0;
            n.dynamic_target_change       = DVS_IDLE;
          end
        end
        DVS_DNW: begin
          if (f.below_lower) begin
            n.vref_goal = r.vref_reg;
            n.force_pwm = 1'b1;
            n.dynamic_target_change       = DVS_DNP;
          end
        end
        DVS_DNP: begin
          if (r.vref_out == r.vref_goal && f.below_lower) begin
            n.force_pwm = 1'b0;
            n.dynamic_target_change       = DVS_IDLE;
          end
        end
        default: n.dynamic_target_change = DVS_IDLE;
      endcase
    end else begin
      n.dynamic_target_change       = DVS_IDLE;
      n.force_pwm = 1'b0;
      if (r.st == ST_SOFT) begin
        n.vref_goal = r.vref_reg;
      end
    end

    // Reference ramp
    step_len = (r.st == ST_SOFT) ? SS_STEP : slew_len(r.slew);
    vref_hit = r.vref_out == r.vref_goal;
    n.step_cnt = '0;
    if (r.st != ST_SOFT && r.st != ST_RUN) begin
      n.vref_out = '0;
    end else if (!vref_hit) begin
      n.step_cnt = r.step_cnt + 16'h1;
      if (r.step_cnt >= step_len - 16'h1) begin
        n.step_cnt = '0;
        n.vref_out = (r.vref_out < r.vref_goal) ? r.vref_out + 8'h1 :
                                                  r.vref_out - 8'h1;
      end
    end

    // Skip bursts and switch phases
    if (f.below_lower) begin
      n.burst = 1'b1;
    end else if (f.above_upper) begin
      n.burst = 1'b0;
    end
    n.ctl.pwm_mode = r.forced_pwm_bit || r.force_pwm || !f.light_load;
    if (n.st != ST_SOFT && n.st != ST_RUN) begin
      n.phase = PH_OFF;
    end else if (f.cyc_start && !r.filt_d.cyc_start &&
                 (r.ctl.pwm_mode || r.burst)) begin
      n.phase = f.mode_buck ? PH_2 : PH_1;
    end else if (f.phase_end && !r.filt_d.phase_end) begin
      n.phase = next_ph(r.phase, f.mode_boost);
    end
    sw = sw_of(n.phase);

    // Bus slave
    acc        = hsel && hready && htrans[1];
    n.ahb_wr   = acc && hwrite && hsize == HSIZE_WORD;
    n.ahb_rd   = acc && !hwrite;
    n.ahb_addr = haddr[ADDR_W-1:0];
    n.hready_q = !(acc && !hwrite);
    n.hresp_q  = 1'b0;
    if (r.ahb_wr && r.ctl.serial_en) begin
      case (r.ahb_addr)
        REG_CTRL: begin
          n.forced_pwm_bit     = hwdata[CTRL_FORCED_PWM_BIT];
          n.switching_frequency_field     = hwdata[CTRL_SWITCHING_FREQUENCY_FIELD +: 2];
          n.switch_current_limit_reg = hwdata[CTRL_SWITCH_CURRENT_LIMIT +: 3];
          n.switch_current_limit_ovr = 1'b1;
          n.slew     = hwdata[CTRL_SLEW +: 2];
        end
        REG_VREF: n.vref_reg = hwdata[VREF_W-1:0];
        default: ;
      endcase
    end
    if (r.ahb_rd) begin
      n.hrdata_q = '0;
      if (r.ctl.serial_en) begin
        case (r.ahb_addr)
          REG_CTRL: n.hrdata_q = {22'h0, r.slew, 1'b0, r.switch_current_limit_reg,
                                  1'b0, r.switching_frequency_field, r.forced_pwm_bit};
          REG_VREF: n.hrdata_q = {24'h0, r.vref_reg};
          REG_STAT: n.hrdata_q = {21'h0, r.force_pwm, r.dynamic_target_change,
                                  r.ctl.pwm_mode, r.ctl.dis_en, f.output_power_good,
                                  r.ctl.latched, 1'b0, r.st};
          REG_CFG:  n.hrdata_q = {21'h0, r.ctl.switch_current_limit_sel, 3'h0,
                                  r.cfg_ext_fb, r.cfg_switch_current_limit, r.cfg_addr};
          default:  n.hrdata_q = '0;
        endcase
      end
    end
    regs_clear = n.st == ST_OFF || n.st == ST_DISCH || !f.io_ok;
    if (regs_clear) begin
      n.vref_reg = VREF_DEF;
      n.forced_pwm_bit     = 1'b0;
      n.switching_frequency_field     = SWITCHING_FREQUENCY_FIELD_DEF;
      n.switch_current_limit_reg = '0;
      n.switch_current_limit_ovr = 1'b0;
      n.slew     = SLEW_DEF;
    end

    // Outputs
    lim = n.switch_current_limit_ovr ? n.switch_current_limit_reg : SWITCH_CURRENT_LIMIT_MAP[n.cfg_switch_current_limit*3 +: 3];
    if (n.st == ST_SOFT && lim > SWITCH_CURRENT_LIMIT_SS) begin
      lim = SWITCH_CURRENT_LIMIT_SS;
    end
    n.ctl.switch_current_limit_sel      = lim;
    n.ctl.bias_en       = n.st != ST_OFF;
    n.ctl.cfg_sample_en = n.st == ST_CFG;
    n.ctl.serial_en     = n.st == ST_SOFT || n.st == ST_RUN ||
                          n.st == ST_LATCH;
    n.ctl.sw_en         = n.st == ST_SOFT || n.st == ST_RUN;
    n.ctl.dis_en        = n.st == ST_DISCH ||
                          (n.st == ST_LATCH && n.dis_on);
    {n.ctl.in_hi_sw, n.ctl.in_lo_sw,
     n.ctl.out_hi_sw, n.ctl.out_lo_sw} = sw;
    n.ctl.switching_frequency_field_sel      = n.switching_frequency_field;
    n.ctl.vref          = n.vref_out;
    n.ctl.slave_addr    = ADDR_MAP[n.cfg_addr*7 +: 7];
    n.ctl.ext_fb        = n.cfg_ext_fb;
    n.ctl.latched       = n.st == ST_LATCH;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= RST_VAL;
    end else begin
      r <= n;
    end
  end

  assign hreadyout = r.hready_q;
  assign hrdata    = r.hrdata_q;
  assign hresp     = r.hresp_q;
  assign ctl_out   = r.ctl;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence run_fault_s;
    r.st == ST_RUN && r.filt.vin_ok && r.filt.io_ok && r.filt.en;
  endsequence

  sequence latch_quiet_s;
    r.st == ST_LATCH ##0 !r.ctl.dis_en ##0 r.ctl.serial_en;
  endsequence

  bias_time_a: assert property ($rose(r.st == ST_CFG) |->
    $past(r.cnt) == BIAS_CYC - CNT_W'(1))
    else $error("bias settle length wrong");
  cfg_time_a: assert property ($rose(r.st == ST_IOCHK) |->
    $past(r.cnt) == CFG_CYC - CNT_W'(1) && $past(r.st) == ST_CFG)
    else $error("config read length wrong");
  io_gate_a: assert property (r.st == ST_IOCHK && !r.filt.io_ok |=>
    !r.ctl.serial_en && !r.ctl.sw_en)
    else $error("serial port on without io supply");
  dis_hold_a: assert property (r.st == ST_DISCH && !r.filt.vout_low &&
    r.cnt < DIS_CYC - CNT_W'(1) && r.filt.vin_ok |=> r.st == ST_DISCH)
    else $error("discharge left early");
  ss_clamp_a: assert property (r.st == ST_SOFT |->
    r.ctl.switch_current_limit_sel <= SWITCH_CURRENT_LIMIT_SS)
    else $error("soft-start limit not clamped");
  en_off_a: assert property (run_fault_s ##1 !r.filt.en |=>
    r.st == ST_DISCH && r.ctl.dis_en && r.vref_reg == VREF_DEF)
    else $error("enable low did not discharge");
  thermal_latch_a: assert property (run_fault_s ##0 r.filt.thermal
    |=> latch_quiet_s)
    else $error("thermal latch wrong");
  no_dis_run_a: assert property (r.ctl.sw_en |-> !r.ctl.dis_en)
    else $error("discharge during regulation");
  leg_short_a: assert property (!(r.ctl.in_hi_sw && r.ctl.in_lo_sw) &&
    !(r.ctl.out_hi_sw && r.ctl.out_lo_sw))
    else $error("switch leg shoot-through");
  forced_pwm_bit_a: assert property (r.forced_pwm_bit |=> r.ctl.pwm_mode)
    else $error("forced pwm ignored");
  uv_off_a: assert property (r.st == ST_RUN && !r.filt.vin_ok |=>
    r.st == ST_DISCH ##1 !r.ctl.serial_en)
    else $error("undervoltage not shut down");

endmodule

// File: verification/bbs_plant.sv
// Output-node model: discharge decay and power-good behaviour
module bbs_plant
  import bbs_pkg::*;
(
  input  wire logic     hclk,
  input  wire bbs_ctl_s ctl,
  input  wire logic     slow,
  output logic          vout_low,
  output logic          output_power_good
);
  timeunit 1ns;
  timeprecision 1ns;
  int n_dis;
  int n_on;
  initial begin
    vout_low = 1'b1;
    output_power_good = 1'b0;
    n_dis = 0;
    n_on = 0;
  end
  // Slow mode never decays, so the discharge timer has to end it
  always @(posedge hclk) begin
    n_dis <= ctl.dis_en ? n_dis + 1 : 0;
    n_on <= ctl.sw_en ? n_on + 1 : 0;
    if (ctl.sw_en) begin
      vout_low <= 1'b0;
    end else if (ctl.dis_en && !slow && n_dis > 20) begin
      vout_low <= 1'b1;
    end
    output_power_good <= n_on > 100;
  end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the buck-boost sequencer
`define CHK(nm, e, a) begin \
  samples_checked++; \
  if ((a) !== (e)) begin \
    n_mismatch++; \
    $display("mismatch %s exp %h got %h", nm, e, a); \
  end \
end
module testbench
  import bbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [CNT_W-1:0] SS = 24'h000200;
  localparam logic [CNT_W-1:0] DC = 24'h0000c8;
  localparam logic [CNT_W-1:0] OC = 24'h000032;
  typedef struct packed {
    logic [3:0]  a;
    logic [31:0] w;
    logic [31:0] d;
    logic [1:0]  f;
    logic        p;
    logic [2:0]  l;
  } bbs_row_s;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        slow, vlow, pk;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  sw;
  logic [31:0] haddr, hwdata, hrdata, r;
  bbs_ana_s    ana, ana_w;
  bbs_ctl_s    ctl;
  int          n_mismatch, samples_checked, n, m, k;
  logic [15:0] ph [3] = '{16'ha600, 16'h9a00, 16'h9a60};
  logic [1:0]  md [3] = '{2'h2, 2'h1, 2'h0};
  bbs_row_s    rows [5] = '{
    '{REG_CTRL, 32'h0, 32'h0, 2'h0, 1'b0, 3'h0},
    '{REG_CTRL, 32'h3, 32'h3, 2'h1, 1'b1, 3'h0},
    '{REG_CTRL, 32'h44, 32'h44, 2'h2, 1'b0, 3'h4},
    '{REG_CTRL, 32'h376, 32'h376, 2'h3, 1'b0, 3'h7},
    '{REG_STAT, 32'h0, 32'h25, 2'h3, 1'b0, 3'h7}};

  assign sw = {ctl.in_hi_sw, ctl.in_lo_sw, ctl.out_hi_sw, ctl.out_lo_sw};
  always_comb begin
    ana_w = ana;
    ana_w.vout_low = vlow;
    ana_w.output_power_good = pk;
  end
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  bbs_sequencer #(.SS_CYC(SS), .DIS_CYC(DC), .OCP_CYC(OC)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .ana_in(ana_w), .ctl_out(ctl));
  bbs_plant pm (.hclk(hclk), .ctl(ctl), .slow(slow), .vout_low(vlow),
    .output_power_good(pk));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic wt(input int c);
    repeat (c) @(posedge hclk);
  endtask

  task automatic ahb(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    haddr <= {28'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  // Start-up with the IO supply held invalid past the resistor read
  task automatic up();
    ana.en <= 1'b1;
    ana.io_ok <= 1'b0;
    for (n = 0; n < 99 && !ctl.bias_en; n++) @(posedge hclk);
    for (n = 0; n < 9999 && !ctl.cfg_sample_en; n++) @(posedge hclk);
    `CHK("bias time", BIAS_CYC, CNT_W'(n))
    for (n = 0; n < 9999 && ctl.cfg_sample_en; n++) @(posedge hclk);
    `CHK("cfg time", CFG_CYC, CNT_W'(n))
    wt(40);
    `CHK("io gate", 1'b0, ctl.serial_en)
    ana.io_ok <= 1'b1;
    for (n = 0; n < 99 && !ctl.serial_en; n++) @(posedge hclk);
    `CHK("sw on", 1'b1, ctl.sw_en)
    `CHK("addr", 7'h6e, ctl.slave_addr)
    `CHK("ext fb", 1'b1, ctl.ext_fb)
    `CHK("ss limit", SWITCH_CURRENT_LIMIT_SS, ctl.switch_current_limit_sel)
    wt(int'(SS) + 9);
    `CHK("run limit", SWITCH_CURRENT_LIMIT_MAP[11:9], ctl.switch_current_limit_sel)
    `CHK("ref", VREF_DEF, ctl.vref)
    `CHK("dis off", 1'b0, ctl.dis_en)
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    wt(60000);
    n_mismatch++;
    print_verdict();
  end

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    slow = 1'b0;
    ana = '0;
    ana.vin_ok = 1'b1;
    ana.light_load = 1'b1;
    ana.cfg_code = 5'h1e;
    n_mismatch = 0;
    samples_checked = 0;
    wt(4);
    `CHK("ready", 1'b1, hreadyout)
    `CHK("bias rst", 1'b0, ctl.bias_en)
    hresetn <= 1'b1;
    wt(2);
    up();
    foreach (rows[j]) begin
      ahb(1'b1, rows[j].a, rows[j].w);
      ahb(1'b0, rows[j].a, 32'h0);
      `CHK("rd", rows[j].d, r)
      `CHK("switching_frequency_field", rows[j].f, ctl.switching_frequency_field_sel)
      `CHK("pwm", rows[j].p, ctl.pwm_mode)
      `CHK("switch_current_limit", rows[j].l, ctl.switch_current_limit_sel)
    end
    ahb(1'b1, REG_CTRL, 32'h1);
    for (m = 0; m < 3; m++) begin
      {ana.mode_buck, ana.mode_boost} <= md[m];
      wt(8);
      for (k = 0; k < 4; k++) begin
        if (k == 0) ana.cyc_start <= 1'b1;
        else ana.phase_end <= 1'b1;
        wt(8);
        `CHK("phase", ph[m][15-4*k -: 4], sw)
        ana.cyc_start <= 1'b0;
        ana.phase_end <= 1'b0;
        wt(8);
      end
    end
    ahb(1'b1, REG_VREF, 32'ha);
    ahb(1'b0, REG_STAT, 32'h0);
    `CHK("dvs pwm", 1'b1, r[10])
    wt(400);
    `CHK("dvs ref", 8'ha, ctl.vref)
    ahb(1'b0, REG_STAT, 32'h0);
    `CHK("dvs done", 1'b0, r[10])
    ana.thermal <= 1'b1;
    wt(10);
    `CHK("latched", 1'b1, ctl.latched)
    `CHK("th dis", 1'b0, ctl.dis_en)
    `CHK("th sw", 1'b0, ctl.sw_en)
    ahb(1'b0, REG_CTRL, 32'h0);
    `CHK("kept", 32'h1, r)
    ana.thermal <= 1'b0;
    ana.en <= 1'b0;
    wt(10);
    `CHK("th off", 1'b0, ctl.bias_en)
    up();
    ana.switch_current_limit_hit <= 1'b1;
    for (n = 0; n < 99 && !ctl.latched; n++) @(posedge hclk);
    `CHK("ocp time", 1'b1, n >= int'(OC) && n <= int'(OC) + 8)
    `CHK("ocp dis", 1'b1, ctl.dis_en)
    ana.switch_current_limit_hit <= 1'b0;
    ana.en <= 1'b0;
    wt(60);
    up();
    ahb(1'b1, REG_CTRL, 32'h6);
    ana.en <= 1'b0;
    wt(8);
    `CHK("sd dis", 1'b1, ctl.dis_en)
    `CHK("sd sw", 1'b0, ctl.sw_en)
    ana.en <= 1'b1;
    for (n = 0; n < 99 && ctl.dis_en; n++) begin
      `CHK("hold", 1'b0, ctl.sw_en)
      @(posedge hclk);
    end
    wt(12);
    `CHK("restart", 1'b1, ctl.bias_en)
    `CHK("sd clear", SWITCHING_FREQUENCY_FIELD_DEF, ctl.switching_frequency_field_sel)
    ana.en <= 1'b0;
    wt(40);
    up();
    slow <= 1'b1;
    ana.io_ok <= 1'b0;
    for (n = 0; n < 99 && !ctl.dis_en; n++) @(posedge hclk);
    `CHK("uv bus", 1'b0, ctl.serial_en)
    ana.en <= 1'b0;
    for (n = 0; n < 999 && ctl.dis_en; n++) @(posedge hclk);
    `CHK("dis timer", 1'b1, n >= int'(DC) - 2 && n <= int'(DC))
    print_verdict();
  end
endmodule
